/* File: src/pin_sync.sv */
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3,
  // per-bit level after reset; match each pin's idle level so no false edge follows reset
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // async in, synchronised out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  // ----------------------------------------
  // stage one is read by stage two only
  // ----------------------------------------
  always_comb begin
    next_stage1 = clkEn ? asyncIn : stage1;
    next_syncOut = clkEn ? stage1 : syncOut;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

/* File: src/scwp_pkg.sv */
// constants used by the serial control word port
package scwp_pkg;

  // ----------------------------------------
  // core clock and polling
  // ----------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 5;
  localparam int POLL_PERIOD_NS = 125000;
  // poll and sample boundary share one period; exact division, no rounding
  localparam int POLL_CYCLES = POLL_PERIOD_NS / CORE_CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // word framing
  // ----------------------------------------
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam int REG_COUNT = 6;
  localparam logic [4:0] WORD_BIT_COUNT = 5'h10;
  localparam logic [1:0] LAST_EXTRA_PULSE = 2'h3;

  // ----------------------------------------
  // register offsets (address nibble b3..b0)
  // ----------------------------------------
  localparam logic [3:0] PREAMP_DUPLEX_VOLUME_CTRL_OFS = 4'h0;
  localparam logic [3:0] TX_VOLUME_TAPS_CTRL_OFS = 4'h2;
  localparam logic [3:0] RX_DETECT_RAMP_CTRL_OFS = 4'h4;
  localparam logic [3:0] TX_SUPPRESSION_TUNING_OFS = 4'h6;
  localparam logic [3:0] ECHO_RETURN_AND_GAIN_CTRL_OFS = 4'h8;
  localparam logic [3:0] FILTER_AND_CANCELLER_DISABLES_OFS = 4'hA;

  // ----------------------------------------
  // reset values (low nibble holds the register's own address)
  // ----------------------------------------
  localparam logic [15:0] PREAMP_DUPLEX_VOLUME_CTRL_RST = 16'hA400;
  localparam logic [15:0] TX_VOLUME_TAPS_CTRL_RST = 16'h2A02;
  localparam logic [15:0] RX_DETECT_RAMP_CTRL_RST = 16'h0004;
  localparam logic [15:0] TX_SUPPRESSION_TUNING_RST = 16'h0006;
  localparam logic [15:0] ECHO_RETURN_AND_GAIN_CTRL_RST = 16'h0008;
  localparam logic [15:0] FILTER_AND_CANCELLER_DISABLES_RST = 16'h000A;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PREAMP_ENABLE_BIT = 15;
  localparam int HALF_DUPLEX_DISABLE_BIT = 14;
  localparam int GRADED_BETA_LSB = 12;
  localparam int RX_VOLUME_LSB = 8;
  localparam int TX_SUPPRESS_DISABLE_BIT = 7;
  localparam int AEC_COEF_CTRL_LSB = 5;
  localparam int NOISE_GUARD_DISABLE_BIT = 4;
  localparam int RECEIVE_ANALOG_GAIN_LSB = 6;
  localparam int TRANSMIT_ANALOG_GAIN_LSB = 4;

  // ----------------------------------------
  // analog gain codes
  // ----------------------------------------
  localparam logic [1:0] GAIN_0_DB = 2'h0;
  localparam logic [1:0] GAIN_6_DB = 2'h1;
  localparam logic [1:0] GAIN_9P5_DB = 2'h2;
  localparam logic [1:0] GAIN_12_DB = 2'h3;

endpackage

/* File: src/serial_control_word_port.sv */
// write-only three-wire serial control word port with six config registers
//
// Behaviour
// (R1) Write-only port; data, shift clock and low frame line load one 16-bit word.
// (R2) Controller starts each transfer by dropping frame while shift clock is low.
// (R3) Word arrives MSB first, bit 15 to bit 0, sixteen bits.
// (R4) Data line captured into shift register on each shift clock rise.
// (R5) After bit 0 frame rises, then four or more pulses commit the word.
// (R6) Shift clock may be arbitrarily slow; only minimum high and low times matter.
// (R7) Port polled every 125 us; writes must be spaced at least that far.
// (R8) Low four bits of the word address the target configuration register.
// (R9) Controller always sends bit 0 as zero.
// (R10) Six registers at codes 0,2,4,6,8,A; upper twelve bits carry fields.
// (R11) Clearing bit 15 of register 0 bypasses the microphone preamplifier.
// (R12) Transmit analog gain selects 0, 6, 9.5 or 12 dB; reset 0 dB.
// (R13) Receive analog gain selects the same four gains; reset 0 dB.
// (R14) Updates take effect on 8 kHz sample boundaries.
// (R15) Every register field takes its marked default after reset.
// (R16) Commit copies upper twelve bits into the addressed register only.
// (R17) Frame, data and shift clock are synchronised before any word is used.
`timescale 1ns/1ps
module serial_control_word_port #(
  parameter int POLL_CYCLES = scwp_pkg::POLL_CYCLES
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // serial pins from the controller
  input wire logic serialData,
  input wire logic shiftClk,
  input wire logic transferFrame_n,
  // configuration registers
  output logic [15:0] preampDuplexVolumeCtrl,
  output logic [15:0] txVolumeTapsCtrl,
  output logic [15:0] rxDetectRampCtrl,
  output logic [15:0] txSuppressionTuning,
  output logic [15:0] echoReturnAndGainCtrl,
  output logic [15:0] filterAndCancellerDisables,
  // decoded controls
  output logic preampEnable,
  output logic preampBypass,
  output logic halfDuplexDisable,
  output logic [1:0] gradedBeta,
  output logic [3:0] rxVolume,
  output logic txSuppressDisable,
  output logic [1:0] aecCoefCtrl,
  output logic noiseGuardDisable,
  output logic [1:0] transmitAnalogGainField,
  output logic [1:0] receiveAnalogGainField,
  // status
  output logic sampleTick,
  output logic wordPending,
  output logic frameErrorPulse,
  output logic overrunPulse,
  output logic ignoredAddrPulse
);

  localparam int TIMER_W = $clog2(POLL_CYCLES + 1);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(POLL_CYCLES - 1);

  typedef enum logic [1:0] {FRM_IDLE, FRM_SHIFT, FRM_COMMIT} frame_state_e;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // maps an address nibble to a register slot; hit is low for undefined codes
  function automatic logic [3:0] decodeAddr(input logic [3:0] addr);
    logic hit;
    logic [2:0] idx;
    hit = 1'b1;
    idx = 3'h0;
    unique case (addr)
      scwp_pkg::PREAMP_DUPLEX_VOLUME_CTRL_OFS: idx = 3'h0;
      scwp_pkg::TX_VOLUME_TAPS_CTRL_OFS: idx = 3'h1;
      scwp_pkg::RX_DETECT_RAMP_CTRL_OFS: idx = 3'h2;
      scwp_pkg::TX_SUPPRESSION_TUNING_OFS: idx = 3'h3;
      scwp_pkg::ECHO_RETURN_AND_GAIN_CTRL_OFS: idx = 3'h4;
      scwp_pkg::FILTER_AND_CANCELLER_DISABLES_OFS: idx = 3'h5;
      default: hit = 1'b0;
    endcase
    return {hit, idx};
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pinSync;
  logic dataSync;
  logic strobeSync;
  logic frameSync_n;
  logic strobeLast;
  logic next_strobeLast;
  logic strobeRise;
  logic frameActive;

  // all three pins share one chain so data, strobe and frame keep their order
  // frame resets to its idle high level, or release would look like a frame start
  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h1)
  ) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .asyncIn({serialData, shiftClk, transferFrame_n}),
    .syncOut(pinSync)
  ); // R17

  assign dataSync = pinSync[2];
  assign strobeSync = pinSync[1];
  assign frameSync_n = pinSync[0];

  // ----------------------------------------
  // shift clock edge detection
  // ----------------------------------------
  // edges found by sampling, so any slow strobe works; 55 ns high/low > 2 periods
  always_comb begin
    next_strobeLast = clkEn ? strobeSync : strobeLast; // R6
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobeLast <= 1'b0;
    end else begin
      strobeLast <= next_strobeLast;
    end
  end

  assign strobeRise = clkEn & strobeSync & ~strobeLast; // R4
  assign frameActive = ~frameSync_n;

  // ----------------------------------------
  // poll timer: one tick per 125 us sample period
  // ----------------------------------------
  logic [TIMER_W-1:0] pollCount;
  logic [TIMER_W-1:0] next_pollCount;
  logic next_sampleTick;

  always_comb begin
    next_pollCount = pollCount;
    next_sampleTick = 1'b0;
    if (clkEn) begin
      if (pollCount == TIMER_LAST) begin
        next_pollCount = '0;
        next_sampleTick = 1'b1; // R7 R14
      end else begin
        next_pollCount = pollCount + TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pollCount <= '0;
      sampleTick <= 1'b0;
    end else begin
      pollCount <= next_pollCount;
      sampleTick <= next_sampleTick;
    end
  end

  // ----------------------------------------
  // frame state machine and shift register
  // ----------------------------------------
  frame_state_e frameState;
  frame_state_e next_frameState;
  logic [15:0] shiftReg;
  logic [15:0] next_shiftReg;
  logic [4:0] bitCount;
  logic [4:0] next_bitCount;
  logic [1:0] extraCount;
  logic [1:0] next_extraCount;
  logic [15:0] pendingWord;
  logic [15:0] next_pendingWord;
  logic next_wordPending;
  logic next_frameErrorPulse;
  logic next_overrunPulse;
  logic commitNow;
  logic consumeNow;

  // the poll takes the pending word on the tick that follows its commit
  assign consumeNow = sampleTick & wordPending & clkEn;

  always_comb begin
    next_frameState = frameState;
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    next_extraCount = extraCount;
    next_frameErrorPulse = 1'b0;
    next_overrunPulse = 1'b0;
    commitNow = 1'b0;
    if (clkEn) begin
      unique case (frameState)
        FRM_IDLE: begin
          if (frameActive) begin
            next_frameState = FRM_SHIFT; // R2
            next_bitCount = strobeRise ? 5'h1 : 5'h0;
            if (strobeRise) begin
              next_shiftReg = {shiftReg[14:0], dataSync}; // R3 R4
            end
          end
        end
        FRM_SHIFT: begin
          if (frameActive) begin
            if (strobeRise) begin
              // older bits fall out the top, so the last sixteen win
              next_shiftReg = {shiftReg[14:0], dataSync}; // R3 R4
              if (bitCount != scwp_pkg::WORD_BIT_COUNT) begin
                next_bitCount = bitCount + 5'h1;
              end
            end
          end else if (bitCount == scwp_pkg::WORD_BIT_COUNT) begin
            next_frameState = FRM_COMMIT;
            next_extraCount = '0;
          end else begin
            // short frame: word dropped, nothing committed
            next_frameState = FRM_IDLE;
            next_frameErrorPulse = 1'b1;
          end
        end
        FRM_COMMIT: begin
          if (frameActive) begin
            // new frame before the fourth pulse abandons the old word
            next_frameState = FRM_SHIFT;
            next_frameErrorPulse = 1'b1;
            next_bitCount = strobeRise ? 5'h1 : 5'h0;
            if (strobeRise) begin
              next_shiftReg = {shiftReg[14:0], dataSync};
            end
          end else if (strobeRise) begin
            if (extraCount == scwp_pkg::LAST_EXTRA_PULSE) begin
              commitNow = 1'b1; // R5
              next_frameState = FRM_IDLE;
            end else begin
              next_extraCount = extraCount + 2'h1;
            end
          end
        end
      endcase
    end
    // a commit in the consume cycle keeps the new word pending
    next_pendingWord = commitNow ? shiftReg : pendingWord;
    next_wordPending = commitNow | (wordPending & ~consumeNow);
    if (commitNow && wordPending && !consumeNow) begin
      next_overrunPulse = 1'b1; // R7
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameState <= FRM_IDLE;
      shiftReg <= '0;
      bitCount <= '0;
      extraCount <= '0;
      pendingWord <= '0;
      wordPending <= 1'b0;
      frameErrorPulse <= 1'b0;
      overrunPulse <= 1'b0;
    end else begin
      frameState <= next_frameState;
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
      extraCount <= next_extraCount;
      pendingWord <= next_pendingWord;
      wordPending <= next_wordPending;
      frameErrorPulse <= next_frameErrorPulse;
      overrunPulse <= next_overrunPulse;
    end
  end

  // ----------------------------------------
  // configuration register file
  // ----------------------------------------
  logic [15:0] regFile [scwp_pkg::REG_COUNT];
  logic [15:0] next_regFile [scwp_pkg::REG_COUNT];
  logic next_ignoredAddrPulse;
  logic [3:0] slot;

  // only the poll writes, so every update lands on a sample boundary
  always_comb begin
    for (int i = 0; i < scwp_pkg::REG_COUNT; i++) begin
      next_regFile[i] = regFile[i];
    end
    next_ignoredAddrPulse = 1'b0;
    slot = decodeAddr(pendingWord[3:0]); // R8
    if (consumeNow) begin // R14
      if (slot[3]) begin
        // low nibble kept from the word; on a hit it equals the register's own code
        next_regFile[slot[2:0]] = {pendingWord[15:4], pendingWord[3:0]}; // R10 R16
      end else begin
        next_ignoredAddrPulse = 1'b1; // R16 R9
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regFile[0] <= scwp_pkg::PREAMP_DUPLEX_VOLUME_CTRL_RST; // R15
      regFile[1] <= scwp_pkg::TX_VOLUME_TAPS_CTRL_RST;
      regFile[2] <= scwp_pkg::RX_DETECT_RAMP_CTRL_RST;
      regFile[3] <= scwp_pkg::TX_SUPPRESSION_TUNING_RST;
      regFile[4] <= scwp_pkg::ECHO_RETURN_AND_GAIN_CTRL_RST;
      regFile[5] <= scwp_pkg::FILTER_AND_CANCELLER_DISABLES_RST;
      ignoredAddrPulse <= 1'b0;
    end else begin
      for (int i = 0; i < scwp_pkg::REG_COUNT; i++) begin
        regFile[i] <= next_regFile[i];
      end
      ignoredAddrPulse <= next_ignoredAddrPulse;
    end
  end

  // ----------------------------------------
  // register outputs and decoded fields
  // ----------------------------------------
  // no path leads back to the pins: the port is write-only
  assign preampDuplexVolumeCtrl = regFile[0]; // R1
  assign txVolumeTapsCtrl = regFile[1];
  assign rxDetectRampCtrl = regFile[2];
  assign txSuppressionTuning = regFile[3];
  assign echoReturnAndGainCtrl = regFile[4];
  assign filterAndCancellerDisables = regFile[5];

  // preamp bypass routes the converter straight to the preamp output pin
  assign preampEnable = regFile[0][scwp_pkg::PREAMP_ENABLE_BIT];
  assign preampBypass = ~regFile[0][scwp_pkg::PREAMP_ENABLE_BIT]; // R11
  assign halfDuplexDisable = regFile[0][scwp_pkg::HALF_DUPLEX_DISABLE_BIT];
  assign gradedBeta = regFile[0][scwp_pkg::GRADED_BETA_LSB +: 2];
  assign rxVolume = regFile[0][scwp_pkg::RX_VOLUME_LSB +: 4];
  assign txSuppressDisable = regFile[0][scwp_pkg::TX_SUPPRESS_DISABLE_BIT];
  assign aecCoefCtrl = regFile[0][scwp_pkg::AEC_COEF_CTRL_LSB +: 2];
  assign noiseGuardDisable = regFile[0][scwp_pkg::NOISE_GUARD_DISABLE_BIT];

  // gain codes follow GAIN_0_DB..GAIN_12_DB in the package
  assign transmitAnalogGainField = regFile[4][scwp_pkg::TRANSMIT_ANALOG_GAIN_LSB +: 2]; // R12
  assign receiveAnalogGainField = regFile[4][scwp_pkg::RECEIVE_ANALOG_GAIN_LSB +: 2]; // R13

endmodule

/* File: test/scwp_ctrl_model.sv */
// behavioural controller driving the three serial control pins
`timescale 1ns/1ps
module scwp_ctrl_model #(
  parameter int HALF_NS = 64
) (
  // serial pins toward the port
  output logic serialData,
  output logic shiftClk,
  output logic transferFrame_n
);
  // idle: frame high, shift clock parked low
  initial begin
    serialData = 1'b0;
    shiftClk = 1'b0;
    transferFrame_n = 1'b1;
  end
  // one transfer; short bit or pulse counts only serve to provoke refusals
  task automatic send(input logic [15:0] w, input int nBits, input int nExtra);
    transferFrame_n = 1'b0;
    #HALF_NS;
    for (int i = 0; i < nBits; i++) begin
      serialData = w[15 - i];
      #HALF_NS shiftClk = 1'b1;
      #HALF_NS shiftClk = 1'b0;
    end
    // released data line flips so a stale bit never looks valid
    serialData = ~serialData;
    transferFrame_n = 1'b1;
    #HALF_NS;
    for (int i = 0; i < nExtra; i++) begin
      shiftClk = 1'b1;
      #HALF_NS shiftClk = 1'b0;
      #HALF_NS;
    end
  endtask
endmodule

/* File: test/scwp_properties.sv */
// checker for the serial control word port outputs
`timescale 1ns/1ps
module scwp_properties #(
  parameter int POLL_CYCLES = 25000
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // registers and decoded controls
  input wire logic [15:0] preampDuplexVolumeCtrl,
  input wire logic [15:0] txVolumeTapsCtrl,
  input wire logic [15:0] rxDetectRampCtrl,
  input wire logic [15:0] txSuppressionTuning,
  input wire logic [15:0] echoReturnAndGainCtrl,
  input wire logic [15:0] filterAndCancellerDisables,
  input wire logic preampEnable,
  input wire logic preampBypass,
  input wire logic [1:0] transmitAnalogGainField,
  input wire logic [1:0] receiveAnalogGainField,
  // status
  input wire logic sampleTick,
  input wire logic wordPending,
  input wire logic frameErrorPulse,
  input wire logic overrunPulse,
  input wire logic ignoredAddrPulse
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  int gap;
  logic seenTick;
  logic [95:0] regs;
  // all six registers in one vector, register at 0x0 on top
  assign regs = {preampDuplexVolumeCtrl, txVolumeTapsCtrl, rxDetectRampCtrl,
    txSuppressionTuning, echoReturnAndGainCtrl, filterAndCancellerDisables};
  // enabled cycles since the last tick; counting from reset, gap reads one higher at the first tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 0;
      seenTick <= 1'b0;
    end else if (clkEn) begin
      gap <= sampleTick ? 0 : gap + 1;
      seenTick <= seenTick | sampleTick;
    end
  end
  a_tick_period: assert property (sampleTick && clkEn && seenTick |-> gap == POLL_CYCLES - 1)
    else $error("sample tick spacing wrong");
  a_tick_due: assert property (gap <= POLL_CYCLES)
    else $error("sample tick overdue");
  a_reg_on_tick: assert property ($changed(regs) |-> $past(sampleTick && wordPending && clkEn))
    else $error("register changed off a sample boundary");
  a_addr_nibble: assert property ({regs[83:80], regs[67:64], regs[51:48], regs[35:32],
    regs[19:16], regs[3:0]} == 24'h02468A) else $error("address nibble corrupted");
  a_preamp_map: assert property (preampEnable == regs[95] && preampBypass == !regs[95])
    else $error("preamp controls do not follow register");
  a_gain_map: assert property (transmitAnalogGainField == regs[21:20] &&
    receiveAnalogGainField == regs[23:22]) else $error("gain fields do not follow register");
  a_reset_values: assert property ($rose(arst_n) |-> regs == {16'hA400, 16'h2A02,
    16'h0004, 16'h0006, 16'h0008, 16'h000A}) else $error("register reset value wrong");
  a_pend_consume: assert property ($fell(wordPending) |-> $past(sampleTick && clkEn))
    else $error("pending word left without a tick");
  a_err_single: assert property (frameErrorPulse && clkEn |=> !frameErrorPulse)
    else $error("frame error pulse too long");
  a_overrun_cause: assert property (overrunPulse |-> $past(wordPending))
    else $error("overrun without pending word");
  a_ignored_cause: assert property (ignoredAddrPulse |-> $past(wordPending))
    else $error("ignored address without pending word");
  c_commit: cover property ($rose(wordPending));
  c_ignored: cover property (ignoredAddrPulse);
  c_frame_err: cover property (frameErrorPulse);
  c_overrun: cover property (overrunPulse);
endmodule

bind serial_control_word_port scwp_properties #(.POLL_CYCLES(POLL_CYCLES)) u_props (
  .core_clk, .arst_n, .clkEn, .preampDuplexVolumeCtrl, .txVolumeTapsCtrl, .rxDetectRampCtrl,
  .txSuppressionTuning, .echoReturnAndGainCtrl, .filterAndCancellerDisables, .preampEnable,
  .preampBypass, .transmitAnalogGainField, .receiveAnalogGainField, .sampleTick,
  .wordPending, .frameErrorPulse, .overrunPulse, .ignoredAddrPulse
);

/* File: test/serial_control_word_port_tb.sv */
// self-checking bench for the serial control word port
`timescale 1ns/1ps
module serial_control_word_port_tb;
  // poll shortened so two words can land inside one period
  localparam int PC = 1600;
  // rows: expected register index beside the word sent
  localparam logic [18:0] ROWS [10] = '{{3'h0, 16'h5A30}, {3'h1, 16'h9E72},
    {3'h2, 16'h3C94}, {3'h3, 16'hF0F6}, {3'h4, 16'h0008}, {3'h4, 16'h6698},
    {3'h4, 16'hAA68}, {3'h4, 16'hFFF8}, {3'h5, 16'h123A}, {3'h0, 16'hC5A0}};
  localparam logic [15:0] BAD [3] = '{16'h1231, 16'hFFFC, 16'h777E};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  wire sd, sc, fr;
  logic [15:0] r [6];
  logic [15:0] expReg [6];
  logic pe, pb, tick, pend, ferr, ovr, ign;
  logic hd, ts, ng;
  logic [1:0] tg, rg, gb, ac;
  logic [3:0] rv;
  int n_fail = 0;
  int samples_checked = 0;
  int nErr, nOvr, nIgn, nTick;

  always #2.5 core_clk = ~core_clk;

  // write-only port: no read path exists, so every check is on outputs
  serial_control_word_port #(.POLL_CYCLES(PC)) dut (
    .core_clk, .arst_n, .clkEn, .serialData(sd), .shiftClk(sc), .transferFrame_n(fr),
    .preampDuplexVolumeCtrl(r[0]), .txVolumeTapsCtrl(r[1]), .rxDetectRampCtrl(r[2]),
    .txSuppressionTuning(r[3]), .echoReturnAndGainCtrl(r[4]),
    .filterAndCancellerDisables(r[5]), .preampEnable(pe), .preampBypass(pb),
    .halfDuplexDisable(hd), .gradedBeta(gb), .rxVolume(rv), .txSuppressDisable(ts),
    .aecCoefCtrl(ac), .noiseGuardDisable(ng), .transmitAnalogGainField(tg),
    .receiveAnalogGainField(rg),
    .sampleTick(tick), .wordPending(pend), .frameErrorPulse(ferr), .overrunPulse(ovr),
    .ignoredAddrPulse(ign));
  scwp_ctrl_model ctrl (.serialData(sd), .shiftClk(sc), .transferFrame_n(fr));

  // sticky counts of the one-cycle status pulses
  always @(posedge core_clk) begin
    if (ferr === 1'b1) nErr++;
    if (ovr === 1'b1) nOvr++;
    if (ign === 1'b1) nIgn++;
    if (tick === 1'b1) nTick++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic chkRegs();
    for (int i = 0; i < 6; i++) chk(r[i], expReg[i]);
    chk({12'h0, tg, rg}, {12'h0, expReg[4][5:4], expReg[4][7:6]});
    chk({14'h0, pe, pb}, {14'h0, expReg[0][15], ~expReg[0][15]});
    chk({1'b0, hd, gb, rv, ts, ac, ng, 4'h0}, {1'b0, expReg[0][14:4], 4'h0});
  endtask
  task automatic doReset();
    #1 arst_n = 1'b0;
    nErr = 0;
    repeat (12) @(posedge core_clk);
    #1 arst_n = 1'b1;
    expReg = '{16'hA400, 16'h2A02, 16'h0004, 16'h0006, 16'h0008, 16'h000A};
    // long enough for a false frame after release to surface as an error pulse
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  // bounded wait until tick (sel=1) or pending (sel=0) shows level v
  task automatic waitSig(input bit sel, input logic v);
    int k;
    k = 0;
    while ((sel ? tick : pend) !== v) begin
      @(posedge core_clk);
      #1 k++;
      if (k > 2 * PC) begin
        n_fail++;
        $display("Error at %0t: wait ran out", $time);
        results();
      end
    end
  endtask
  task automatic put(input logic [15:0] w, input int nb, input int ne);
    @(posedge core_clk);
    #1 nErr = 0;
    nOvr = 0;
    nIgn = 0;
    ctrl.send(w, nb, ne);
  endtask
  task automatic settle();
    waitSig(1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    doReset();
    chkRegs();
    chk(16'(nErr), 16'h0);
    foreach (ROWS[i]) begin
      put(ROWS[i][15:0], 16, 4);
      settle();
      expReg[ROWS[i][18:16]] = ROWS[i][15:0];
      chkRegs();
    end
    // undefined address nibbles, one with bit 0 set
    foreach (BAD[i]) begin
      put(BAD[i], 16, 4);
      settle();
      chk(16'(nIgn > 0), 16'h1);
      chkRegs();
    end
    // frame closed after fifteen bits
    put(16'h7770, 15, 4);
    settle();
    chk(16'(nErr > 0), 16'h1);
    chkRegs();
    // commit cut short by a new frame, which then lands
    put(16'h4440, 16, 2);
    put(16'h1112, 16, 4);
    settle();
    expReg[1] = 16'h1112;
    chk(16'(nErr > 0), 16'h1);
    chkRegs();
    // two words inside one poll period: only the later survives
    waitSig(1'b1, 1'b1);
    put(16'h2224, 16, 4);
    put(16'h3336, 16, 4);
    settle();
    expReg[3] = 16'h3336;
    chk(16'(nOvr > 0), 16'h1);
    chkRegs();
    // clock enable low freezes the poll timer
    waitSig(1'b1, 1'b1);
    @(posedge core_clk);
    #1 clkEn = 1'b0;
    nTick = 0;
    repeat (PC + 10) @(posedge core_clk);
    #1 chk(16'(nTick), 16'h0);
    clkEn = 1'b1;
    // reset in mid-run restores defaults
    doReset();
    chkRegs();
    chk(16'(nErr), 16'h0);
    results();
  end
endmodule
